//--- logic/bsc_params.svh
// Widths, field positions and reset values of the burst SRAM.
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// Address bus width: 65,536 words
`define BSC_ADDR_W 16
// Data word width
`define BSC_DATA_W 18
// Width of one byte lane (nine bits, parity included)
`define BSC_LANE_W 9
// Number of byte lanes
`define BSC_LANES 2
// Burst counter width, also the number of low address bits it replaces
`define BSC_BURST_W 2
// Lane index of the lower byte write
`define BSC_LANE_LO 0
// Lane index of the upper byte write
`define BSC_LANE_HI 1

// Reset value of the held upper address
`define BSC_UPPER_RST 14'h0000
// Reset value of the burst counter and base bits
`define BSC_BURST_RST 2'h0
// Reset value of the captured write data
`define BSC_DATA_RST 18'h0_0000
// Reset value of the lane write enables
`define BSC_LANES_RST 2'h0

`endif

//--- logic/bsc_pkg.sv
// Types shared by the burst SRAM modules.
package bsc_pkg;

	// Kind of access performed in the current cycle
	typedef enum logic [1:0] {
		OP_IDLE,
		OP_READ,
		OP_WRITE
	} bsc_op_t;

endpackage : bsc_pkg

//--- logic/bsc_access_if.sv
// Signals between the control, the burst counter and the word array.
`timescale 1ns/1ps
`include "bsc_params.svh"

interface bsc_access_if #(
	parameter int ADDR_W = `BSC_ADDR_W,
	parameter int DATA_W = `BSC_DATA_W
);
	logic load; // Load a new base into the counter
	logic step; // Advance the burst position
	logic [`BSC_BURST_W-1:0] loadLow; // Low base address bits
	logic [`BSC_BURST_W-1:0] lowAddr; // Current low address bits
	logic [ADDR_W-1:0] addr; // Full word address of this cycle
	logic [DATA_W-1:0] wdata; // Captured write data
	logic [`BSC_LANES-1:0] laneWr; // Byte lanes to write
	logic wrEn; // Array write in this cycle
	logic [DATA_W-1:0] rdata; // Word read at addr

	// Cycle control
	modport ctrl (
		output load, step, loadLow, addr, wdata, laneWr, wrEn,
		input lowAddr, rdata
	);
	// Burst counter
	modport burst (
		input load, step, loadLow,
		output lowAddr
	);
	// Storage array
	modport array (
		input addr, wdata, laneWr, wrEn,
		output rdata
	);
endinterface : bsc_access_if

//--- logic/bsc_burst_counter.sv
// Two-bit interleaved burst counter with wrap to the base address.
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_burst_counter (
	input wire logic ref_clk,
	input wire logic rstn,
	bsc_access_if.burst acc
);
	logic [`BSC_BURST_W-1:0] base_ff; // Low bits of the base address
	logic [`BSC_BURST_W-1:0] count_ff; // Accesses advanced so far

	// Base bits are held for the whole burst
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			base_ff <= `BSC_BURST_RST;
		end else if (acc.load) begin
			base_ff <= acc.loadLow;
		end
	end

	// Position counter; a two-bit sum wraps back to zero after four
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			count_ff <= `BSC_BURST_RST;
		end else if (acc.load) begin
			count_ff <= `BSC_BURST_RST;
		end else if (acc.step) begin
			count_ff <= count_ff + 2'h1;
		end
	end

	// Counts 1, 2, 3 invert A0, then A1, then both
	assign acc.lowAddr = base_ff ^ count_ff;

endmodule : bsc_burst_counter

//--- logic/bsc_word_array.sv
// Storage array with two byte lanes and an unregistered read port.
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_word_array #(
	parameter int ADDR_W = `BSC_ADDR_W,
	parameter int LANE_W = `BSC_LANE_W
) (
	input wire logic ref_clk,
	bsc_access_if.array acc
);
	localparam int WORDS = 2 ** ADDR_W;

	logic [LANE_W-1:0] loMem [WORDS]; // Lower lane storage
	logic [LANE_W-1:0] hiMem [WORDS]; // Upper lane storage

	// Lower lane, written at the close of the write cycle
	always_ff @(posedge ref_clk) begin
		if (acc.wrEn && acc.laneWr[`BSC_LANE_LO]) begin
			loMem[acc.addr] <= acc.wdata[LANE_W-1:0];
		end
	end

	// Upper lane, written at the close of the write cycle
	always_ff @(posedge ref_clk) begin
		if (acc.wrEn && acc.laneWr[`BSC_LANE_HI]) begin
			hiMem[acc.addr] <= acc.wdata[2*LANE_W-1:LANE_W];
		end
	end

	// Read is combinational from the registered address
	assign acc.rdata = {hiMem[acc.addr], loMem[acc.addr]};

endmodule : bsc_word_array

//--- logic/bsc_burst_sram.sv
// Top of the burst SRAM: input capture, cycle decode and data bus control.
//
// Operation
// - 65,536 words of 18 bits, 16-bit address
// - Register address, data, controls on clock edge
// - Write starts at edge, self-timed internally
// - Lower write bits 0-8, upper 9-17
// - Processor strobe aborts burst, loads, reads
// - Controller strobe loads; writes if lane enabled
// - Chip enable sampled at load; high deselects
// - Deselected chip ignores processor strobe
// - No strobe: continue or suspend burst
// - Step low advances address before access
// - Step high repeats access as wait
// - Two-bit counter from base low bits
// - Interleaved order: A0, A1, both inverted
// - Fourth advance returns to base address
// - Output enable drives reads asynchronously
// - One shared bidirectional 18-bit data bus
// - Data bus floats from reset until read
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_burst_sram #(
	parameter int ADDR_W = `BSC_ADDR_W,
	parameter int DATA_W = `BSC_DATA_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addrBus,
	input wire logic [DATA_W-1:0] dataBusIn,
	output logic [DATA_W-1:0] dataBusOut,
	output logic dataBusOen_n,
	input wire logic cpuAddrStrobe_n,
	input wire logic ctrlAddrStrobe_n,
	input wire logic burstStep_n,
	input wire logic lowerByteWrite_n,
	input wire logic upperByteWrite_n,
	input wire logic chipOn_n,
	input wire logic outputOn_n
);
	localparam int LANE_W = DATA_W / `BSC_LANES;
	localparam int UPPER_W = ADDR_W - `BSC_BURST_W;

	// Refuse shapes the lane split or the counter cannot serve
	if (DATA_W != `BSC_LANES * LANE_W || DATA_W < `BSC_LANES) begin : gChkData
		$error("data width must split into two equal lanes");
	end
	if (ADDR_W <= `BSC_BURST_W) begin : gChkAddr
		$error("address must be wider than the burst counter");
	end

	// Lanes requested by the active-low byte write pins
	function automatic logic [`BSC_LANES-1:0] laneMask(
		input logic lowerN,
		input logic upperN
	);
		logic [`BSC_LANES-1:0] mask;
		mask = `BSC_LANES_RST;
		mask[`BSC_LANE_LO] = !lowerN;
		mask[`BSC_LANE_HI] = !upperN;
		return mask;
	endfunction : laneMask

	// Access kind for a cycle whose write enables are honoured
	function automatic bsc_pkg::bsc_op_t opFromLanes(
		input logic [`BSC_LANES-1:0] mask
	);
		opFromLanes = (|mask) ? bsc_pkg::OP_WRITE : bsc_pkg::OP_READ;
	endfunction : opFromLanes

	bsc_access_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) acc ();

	bsc_pkg::bsc_op_t op_ff; // Access kind of the current cycle
	bsc_pkg::bsc_op_t nxt_op; // Access kind for the next cycle
	logic [UPPER_W-1:0] upperAddr_ff; // Upper bits, fixed for a burst
	logic [DATA_W-1:0] wdata_ff; // Write data captured at the edge
	logic [`BSC_LANES-1:0] laneWr_ff; // Lanes written this cycle
	logic [`BSC_LANES-1:0] nxt_laneWr; // Lanes for the next cycle
	logic [`BSC_LANES-1:0] pinLanes; // Lanes asked by the pins now
	logic loadBase; // A new base address is taken
	logic stepBurst; // The burst position advances
	logic cpuTake; // Processor strobe honoured

	// Processor strobe counts only while the chip is enabled
	assign cpuTake = !cpuAddrStrobe_n && !chipOn_n;
	assign pinLanes = laneMask(lowerByteWrite_n, upperByteWrite_n);

	// Decode of strobes, chip enable and step at the coming edge
	always_comb begin
		nxt_op = op_ff;
		nxt_laneWr = `BSC_LANES_RST;
		loadBase = 1'b0;
		stepBurst = 1'b0;
		if (cpuTake) begin
			// Abort any burst, new base, read regardless of writes
			loadBase = 1'b1;
			nxt_op = bsc_pkg::OP_READ;
		end else if (!ctrlAddrStrobe_n) begin
			if (chipOn_n) begin
				// Chip enable is looked at only here and in cpuTake
				nxt_op = bsc_pkg::OP_IDLE;
			end else begin
				loadBase = 1'b1;
				nxt_laneWr = pinLanes;
				nxt_op = opFromLanes(pinLanes);
			end
		end else begin
			// No strobe: chip enable plays no part
			case (op_ff)
				bsc_pkg::OP_READ, bsc_pkg::OP_WRITE: begin
					stepBurst = !burstStep_n;
					nxt_laneWr = pinLanes;
					nxt_op = opFromLanes(pinLanes);
				end
				bsc_pkg::OP_IDLE: begin
					// Deselected device stays deselected
					nxt_op = bsc_pkg::OP_IDLE;
				end
				default: begin
					nxt_op = bsc_pkg::OP_IDLE;
				end
			endcase
		end
	end

	// Access kind register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			op_ff <= bsc_pkg::OP_IDLE;
		end else begin
			op_ff <= nxt_op;
		end
	end

	// Upper address, taken only with a new base
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			upperAddr_ff <= UPPER_W'(`BSC_UPPER_RST);
		end else if (loadBase) begin
			upperAddr_ff <= addrBus[ADDR_W-1:`BSC_BURST_W];
		end
	end

	// Write data from the shared bus, captured on every edge
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wdata_ff <= DATA_W'(`BSC_DATA_RST);
		end else begin
			wdata_ff <= dataBusIn;
		end
	end

	// Lane write enables of the cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			laneWr_ff <= `BSC_LANES_RST;
		end else begin
			laneWr_ff <= nxt_laneWr;
		end
	end

	// Counter load and advance, taken at the same edge as the pins
	assign acc.load = loadBase;
	assign acc.step = stepBurst;
	assign acc.loadLow = addrBus[`BSC_BURST_W-1:0];

	// Array access of the current cycle; write needs no pulse
	assign acc.addr = {upperAddr_ff, acc.lowAddr};
	assign acc.wdata = wdata_ff;
	assign acc.laneWr = laneWr_ff;
	assign acc.wrEn = (op_ff == bsc_pkg::OP_WRITE);

	bsc_burst_counter uCounter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.acc(acc)
	);

	bsc_word_array #(.ADDR_W(ADDR_W), .LANE_W(LANE_W)) uArray (
		.ref_clk(ref_clk),
		.acc(acc)
	);

	// Read word straight from the array, zero when not reading
	assign dataBusOut = (op_ff == bsc_pkg::OP_READ) ?
		acc.rdata : DATA_W'(`BSC_DATA_RST);

	// Drive only on a read with output enable low, no clock involved
	assign dataBusOen_n = (op_ff != bsc_pkg::OP_READ) || outputOn_n;

endmodule : bsc_burst_sram

//--- verification/bsc_burst_sram_chk.sv
// Pin-level assertions for the burst SRAM top.
`timescale 1ns/1ps
module bsc_burst_sram_chk #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 18
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addrBus,
	input wire logic [DATA_W-1:0] dataBusIn,
	input wire logic [DATA_W-1:0] dataBusOut,
	input wire logic dataBusOen_n,
	input wire logic cpuAddrStrobe_n,
	input wire logic ctrlAddrStrobe_n,
	input wire logic burstStep_n,
	input wire logic lowerByteWrite_n,
	input wire logic upperByteWrite_n,
	input wire logic chipOn_n,
	input wire logic outputOn_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Honoured processor strobe
	wire logic cpuGo = !cpuAddrStrobe_n && !chipOn_n;
	// Controller strobe starting a write
	wire logic ctlWr = cpuAddrStrobe_n && !ctrlAddrStrobe_n && !chipOn_n
		&& !(lowerByteWrite_n && upperByteWrite_n);
	// Controller strobe while not enabled
	wire logic desel = !ctrlAddrStrobe_n && chipOn_n;
	// Read continuation with the burst held
	wire logic hold = cpuAddrStrobe_n && ctrlAddrStrobe_n && burstStep_n
		&& lowerByteWrite_n && upperByteWrite_n;

	a_oe_async: assert property (outputOn_n |-> dataBusOen_n)
		else $error("bus driven with output enable off");
	a_cpu_read: assert property (cpuGo ##1 !outputOn_n |-> !dataBusOen_n)
		else $error("processor strobe gave no read");
	a_write_float: assert property (ctlWr |=> dataBusOen_n && dataBusOut == '0)
		else $error("bus driven in write cycle");
	a_cont_write: assert property (cpuAddrStrobe_n && ctrlAddrStrobe_n
		&& !lowerByteWrite_n |=> dataBusOen_n)
		else $error("bus driven in continued write");
	a_desel_float: assert property (desel |=> dataBusOen_n)
		else $error("bus driven after deselect");
	a_desel_stays: assert property (desel ##1 chipOn_n |=> dataBusOen_n)
		else $error("deselected part started a cycle");
	a_suspend_hold: assert property (!dataBusOen_n && hold ##1 !outputOn_n
		|-> $stable(dataBusOut))
		else $error("held burst changed read word");
	a_reset_float: assert property (disable iff (1'b0)
		!rstn |-> dataBusOen_n && dataBusOut == '0)
		else $error("bus driven during reset");
	c_cpu_read: cover property (cpuGo ##1 !dataBusOen_n);
	c_ctl_write: cover property (ctlWr);
	c_hold: cover property (!dataBusOen_n && hold);
endmodule : bsc_burst_sram_chk

bind bsc_burst_sram bsc_burst_sram_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
	chk (.*);

//--- verification/bsc_host_model.sv
// Host side of the shared data bus: drives writes, floats otherwise.
`timescale 1ns/1ps
module bsc_host_model #(
	parameter int W = 18
) (
	input wire logic ref_clk,
	input wire logic [W-1:0] devOut,
	input wire logic devOen_n,
	input wire logic hostDrv,
	input wire logic [W-1:0] hostData,
	output logic [W-1:0] busLvl,
	output logic clash
);
	logic [W-1:0] idlePat = 18'h2_AAAA; // Floating bus pattern
	// Undriven bus changes every cycle, never keeps a value
	always @(posedge ref_clk) idlePat <= ~idlePat;
	// Device drives reads, host drives writes
	assign busLvl = !devOen_n ? devOut : hostDrv ? hostData : idlePat;
	// Both parties driving is contention
	assign clash = !devOen_n && hostDrv;
endmodule : bsc_host_model

//--- verification/test_burst_sram_control.sv
// Self-checking bench of the burst SRAM with a host bus model.
`timescale 1ns/1ps
module test_burst_sram_control;
	localparam logic [5:0] RD = 6'h1E, WR = 6'h28, NR = 6'h37, NW = 6'h31;
	localparam logic [5:0] HR = 6'h3F, DS = 6'h2F, LO = 6'h2A, UP = 6'h2C;
	logic ref_clk = 1'b0;
	logic rstn = 1'b1;
	logic [15:0] addrBus = 16'h0000;
	logic [17:0] hostData = 18'h0_0000;
	logic hostDrv = 1'b0;
	logic cpuStb_n = 1'b1, ctlStb_n = 1'b1, step_n = 1'b1;
	logic lowWr_n = 1'b1, upWr_n = 1'b1, chip_n = 1'b1, outOn_n = 1'b1;
	logic [17:0] busLvl, devOut;
	logic devOen_n, clash;
	int err_total = 0;
	int checked = 0;
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	bsc_burst_sram dut (.ref_clk(ref_clk), .rstn(rstn), .addrBus(addrBus),
		.dataBusIn(busLvl), .dataBusOut(devOut), .dataBusOen_n(devOen_n),
		.cpuAddrStrobe_n(cpuStb_n), .ctrlAddrStrobe_n(ctlStb_n),
		.burstStep_n(step_n), .lowerByteWrite_n(lowWr_n),
		.upperByteWrite_n(upWr_n), .chipOn_n(chip_n), .outputOn_n(outOn_n));
	bsc_host_model host (.ref_clk(ref_clk), .devOut(devOut),
		.devOen_n(devOen_n), .hostDrv(hostDrv), .hostData(hostData),
		.busLvl(busLvl), .clash(clash));
	// Word stored at each address
	function automatic logic [17:0] pat(input logic [15:0] a);
		return {2'h1, a};
	endfunction : pat
	// One cycle: drive at falling edge, return a cycle later
	task automatic cyc(input logic [5:0] c, input logic [15:0] a,
		input logic [17:0] d);
		{cpuStb_n, ctlStb_n, step_n, lowWr_n, upWr_n, chip_n} = c;
		addrBus = a;
		hostData = d;
		hostDrv = !(c[2] && c[1]);
		outOn_n = hostDrv;
		@(negedge ref_clk);
	endtask : cyc
	// Bus carries a driven read word
	task automatic cmpBus(input logic [17:0] exp);
		checked++;
		if (busLvl !== exp || devOen_n !== 1'b0 || clash !== 1'b0) begin
			err_total++;
			$display("wrong value at %0t: bus %h not %h", $time, busLvl, exp);
		end
	endtask : cmpBus
	// Output enable level
	task automatic cmpOe(input logic exp);
		checked++;
		if (devOen_n !== exp) begin
			err_total++;
			$display("wrong value at %0t: enable %b", $time, devOen_n);
		end
	endtask : cmpOe
	// Write burst from a controller strobe, then continued writes
	task automatic tWriteBurst();
		cyc(WR, 16'h1232, pat(16'h1232));
		cmpOe(1'b1);
		cyc(NW, 16'h0000, pat(16'h1233));
		cyc(NW, 16'h0000, pat(16'h1230));
		cyc(NW, 16'h0000, pat(16'h1231));
		cmpOe(1'b1);
	endtask : tWriteBurst
	// Read burst with wrap and a wait state
	task automatic tReadBurst();
		cyc(RD, 16'h1231, 18'h0_0000);
		cmpBus(pat(16'h1231));
		for (int k = 1; k < 5; k++) begin
			cyc(NR, 16'hFFFF, 18'h0_0000);
			cmpBus(pat(16'h1231 ^ 16'(k % 4)));
		end
		cyc(HR, 16'hFFFF, 18'h0_0000);
		cmpBus(pat(16'h1231));
	endtask : tReadBurst
	// Single lane writes keep the other lane
	task automatic tLanes();
		cyc(LO, 16'h1230, 18'h3_FFFF);
		cyc(UP, 16'h1231, 18'h0_0000);
		cyc(RD, 16'h1230, 18'h0_0000);
		cmpBus({9'(pat(16'h1230) >> 9), 9'h1FF});
		cyc(NR, 16'h0000, 18'h0_0000);
		cmpBus({9'h000, 9'(pat(16'h1231))});
	endtask : tLanes
	// Strobes against chip enable
	task automatic tSelect();
		cyc(RD, 16'h1232, 18'h0_0000);
		cyc(6'h1F, 16'h0000, 18'h0_0000);
		cmpBus(pat(16'h1232));
		cyc(DS, 16'h0000, 18'h0_0000);
		cmpOe(1'b1);
		cyc(NR, 16'h0000, 18'h0_0000);
		cmpOe(1'b1);
		cyc(6'h08, 16'h1233, 18'h0_0000);
		cyc(RD, 16'h1233, 18'h0_0000);
		cmpBus(pat(16'h1233));
	endtask : tSelect
	// Output enable acts inside the cycle
	task automatic tAsync();
		cyc(RD, 16'h1232, 18'h0_0000);
		#5 outOn_n = 1'b1;
		#1 cmpOe(1'b1);
		outOn_n = 1'b0;
		#1 cmpBus(pat(16'h1232));
		@(negedge ref_clk);
	endtask : tAsync
	// Print counts and verdict, then stop
	task automatic summarize();
		$display("mismatches %0d, checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// Main sequence
	initial begin
		// Real falling edge on reset so every register but the word array clears before a clock
		#1 rstn = 1'b0;
		repeat (6) @(negedge ref_clk);
		cmpOe(1'b1);
		rstn = 1'b1;
		tWriteBurst();
		tReadBurst();
		tLanes();
		tSelect();
		tAsync();
		summarize();
	end
	// Hang guard
	initial begin
		repeat (400) @(posedge ref_clk);
		err_total++;
		summarize();
	end
endmodule : test_burst_sram_control
